// File: rtl/eeprom_cache_regs.vh
// How it works
// RULE1: first data byte lands in cache page 0
// RULE2: low three address bits pick starting byte position
// RULE3: full cache wraps trailing bytes into page 0
// RULE4: excess bytes overwrite earlier cache contents
// RULE5: commit page 0 first, then following pages
// RULE6: one timed write cycle per committed page
// RULE7: only loaded byte positions reach the array
// RULE8: standby after stop and idle internals
// RULE9: standby also after aborted transactions
// RULE10: low voltage blocks writes; monitor off in standby
// RULE11: answer only when chip-select bits match straps
// RULE12: data line only pulled low or released
// RULE13: data changes only while clock is low
// RULE14: cache is eight pages of eight bytes
// RULE15: fixed cycle per page; ignore commands meanwhile
// RULE16: control byte not acknowledged while busy
// RULE17: upper address bits pick first array page
`ifndef EEPROM_CACHE_REGS_VH
`define EEPROM_CACHE_REGS_VH

// control byte device type code, upper nibble
`define CTRL_CODE 4'hA
// byte index of the first data byte
`define FIRST_DATA_IDX 2'h3
// bits per byte on the bus
`define BITS_PER_BYTE 4'h8
// last byte position inside a cache page
`define LAST_BYTE_POS 3'h7

// per-page write cycle time in clocks: 5 ms at a 10 ns clock
`define WR_CYCLES 20'h7A120

`endif

// File: rtl/bus_pin_sampler.v
module bus_pin_sampler (
  // clock, reset, enable
  input wire clk,
  input wire resetn,
  input wire ce,
  // raw bus pins
  input wire scl_i,
  input wire sda_i,
  // synchronised levels and events
  output wire scl_s,
  output wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);

  reg [1:0] scl_sync_reg; // two-stage synchroniser for clock pin
  reg [1:0] sda_sync_reg; // two-stage synchroniser for data pin
  reg scl_prev_reg; // previous synchronised clock level
  reg sda_prev_reg; // previous synchronised data level

  ////////////////////////////////////////////////////////////////////////////
  // synchronise pins, then keep one older sample for edge detection
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edges and bus conditions, all from the second stage onward
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = ce & scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall = ce & ~scl_sync_reg[1] & scl_prev_reg;
  // data moving while clock stays high marks start or stop
  assign start_det = ce & scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1]; // [RULE13]
  assign stop_det = ce & scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1]; // [RULE13]

endmodule

// File: rtl/eeprom_write_cache.v
`include "eeprom_cache_regs.vh"

module eeprom_write_cache #(
  parameter [19:0] write_cycles = `WR_CYCLES
) (
  // clock, reset, enable
  input wire clk,
  input wire resetn,
  input wire ce,
  // two-wire bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // chip address straps
  input wire chip_select_bit0,
  input wire chip_select_bit1,
  input wire chip_select_bit2,
  // supply monitor
  input wire low_voltage_i,
  output wire monitor_en,
  // array write port
  output reg array_we,
  output reg [12:0] array_addr,
  output reg [7:0] array_data,
  // power state
  output reg standby
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam [3:0] ST_IDLE = 4'b0001; // no transaction
  localparam [3:0] ST_RX = 4'b0010; // shifting in a byte
  localparam [3:0] ST_ACK = 4'b0100; // holding acknowledge low
  localparam [3:0] ST_SKIP = 4'b1000; // not addressed, wait for start or stop
  localparam [2:0] CM_IDLE = 3'b001; // commit engine idle
  localparam [2:0] CM_BYTE = 3'b010; // walking byte positions of a page
  localparam [2:0] CM_WAIT = 3'b100; // timed array write cycle
  wire scl_s; // synchronised clock level
  wire sda_s; // synchronised data level
  wire scl_rise; // clock rising edge
  wire scl_fall; // clock falling edge
  wire start_det; // start condition
  wire stop_det; // stop condition
  reg [3:0] bus_state_reg; // bus-side state
  reg [7:0] shift_reg; // incoming byte
  reg [3:0] bit_cnt_reg; // bits received in current byte
  reg [1:0] byte_idx_reg; // 0 control, 1 high addr, 2 low addr, 3 data
  reg sda_oe_reg; // pull data line low
  reg [4:0] addr_hi_reg; // upper address byte bits
  reg [9:0] base_page_reg; // array page for cache page 0
  reg [5:0] wr_ptr_reg; // next cache position
  reg [63:0] loaded_reg; // cache positions holding data
  reg [2:0] last_page_reg; // highest cache page used
  reg [7:0] cache_mem [0:63]; // eight pages of eight bytes
  reg [2:0] cm_state_reg; // commit engine state
  reg [2:0] cpage_reg; // cache page being committed
  reg [2:0] cbyte_reg; // byte position being committed
  reg [19:0] timer_reg; // write cycle timer
  reg busy_reg; // internal write in progress
  reg [5:0] strap_sync_reg; // two-stage synchroniser for straps
  reg [1:0] lv_sync_reg; // two-stage synchroniser for supply monitor
  reg ack_now; // this byte gets acknowledged
  reg store_now; // this byte goes into the cache
  reg commit_go; // stop ends a loaded write
  wire [2:0] strap_s; // strapped chip select levels
  wire lv_s; // low voltage flag
  wire [5:0] cidx; // cache index under commit
  // array page for a cache page, wrapping over the array
  function [9:0] page_of;
    input [9:0] base;
    input [2:0] offs;
    begin
      page_of = base + {7'h00, offs};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  bus_pin_sampler u_pins (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );
  // straps and monitor flag through two flip-flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_sync_reg <= 6'h00;
      lv_sync_reg <= 2'h0;
    end else if (ce) begin
      strap_sync_reg <= {strap_sync_reg[2:0], chip_select_bit2, chip_select_bit1, chip_select_bit0};
      lv_sync_reg <= {lv_sync_reg[0], low_voltage_i};
    end
  end
  assign strap_s = strap_sync_reg[5:3];
  assign lv_s = lv_sync_reg[1];
  assign cidx = {cpage_reg, cbyte_reg}; // page-major cache index
  // open drain: drive only low, enable only when pulling
  assign sda_o = 1'b0; // [RULE12]
  assign sda_oe = sda_oe_reg; // [RULE12]
  // supply monitor powered only outside standby
  assign monitor_en = ~standby; // [RULE10]

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge decision for the byte just shifted in
  always @* begin
    ack_now = 1'b0;
    store_now = 1'b0;
    case (byte_idx_reg)
      2'h0: begin
        // type code, matching straps, write direction, not busy
        ack_now = (shift_reg[7:4] == `CTRL_CODE) && (shift_reg[3:1] == strap_s) // [RULE11]
                  && !shift_reg[0] && !busy_reg; // [RULE15] [RULE16]
      end
      2'h1, 2'h2: begin
        // address bytes are always acknowledged
        ack_now = 1'b1;
      end
      default: begin
        ack_now = 1'b1;
        store_now = 1'b1;
      end
    endcase
  end
  // stop after at least one data byte starts the commit
  always @* begin
    commit_go = stop_det && (byte_idx_reg == `FIRST_DATA_IDX) && (loaded_reg != 64'h0) && !busy_reg; // [RULE14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus-side byte receiver and acknowledge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      sda_oe_reg <= 1'b0;
      addr_hi_reg <= 5'h00;
      base_page_reg <= 10'h000;
      wr_ptr_reg <= 6'h00;
      loaded_reg <= 64'h0;
      last_page_reg <= 3'h0;
    end else if (ce) begin
      if (stop_det) begin
        // stop always returns to idle, abort or not
        bus_state_reg <= ST_IDLE; // [RULE8] [RULE9]
        sda_oe_reg <= 1'b0;
        byte_idx_reg <= 2'h0;
      end else if (start_det) begin
        // start or repeated start restarts framing
        bus_state_reg <= ST_RX; // [RULE9]
        sda_oe_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        byte_idx_reg <= 2'h0;
      end else begin
        case (bus_state_reg)
          ST_RX: begin
            if (scl_rise) begin
              // sample data in the clock high phase
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && (bit_cnt_reg == `BITS_PER_BYTE)) begin
              if (ack_now) begin
                // pull low just after clock fell
                sda_oe_reg <= 1'b1; // [RULE13]
                bus_state_reg <= ST_ACK;
                if (byte_idx_reg != `FIRST_DATA_IDX) begin
                  byte_idx_reg <= byte_idx_reg + 2'h1;
                end
                if (byte_idx_reg == 2'h1) begin
                  addr_hi_reg <= shift_reg[4:0];
                end
                if (byte_idx_reg == 2'h2) begin
                  base_page_reg <= {addr_hi_reg, shift_reg[7:3]}; // [RULE17]
                  wr_ptr_reg <= {3'h0, shift_reg[2:0]}; // [RULE1] [RULE2]
                  loaded_reg <= 64'h0;
                  last_page_reg <= 3'h0;
                end
                if (store_now) begin
                  // pointer wraps at 64, refilling page 0 and overwriting
                  wr_ptr_reg <= wr_ptr_reg + 6'h01; // [RULE3] [RULE4]
                  loaded_reg[wr_ptr_reg] <= 1'b1; // [RULE7]
                  if (wr_ptr_reg[5:3] > last_page_reg) begin
                    last_page_reg <= wr_ptr_reg[5:3];
                  end
                end
              end else begin
                // not for us or busy: leave line released
                bus_state_reg <= ST_SKIP; // [RULE11] [RULE16]
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              // release after acknowledge clock, still clock low
              sda_oe_reg <= 1'b0; // [RULE13]
              bit_cnt_reg <= 4'h0;
              bus_state_reg <= ST_RX;
            end
          end
          ST_SKIP: begin
            bus_state_reg <= ST_SKIP;
          end
          default: begin
            bus_state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cache storage, written once per acknowledged data byte
  always @(posedge clk) begin
    if (ce && !stop_det && !start_det && (bus_state_reg == ST_RX) && scl_fall
        && (bit_cnt_reg == `BITS_PER_BYTE) && ack_now && store_now) begin
      cache_mem[wr_ptr_reg] <= shift_reg; // [RULE1] [RULE3] [RULE4] [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commit engine: page 0 first, one timed cycle per page
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cm_state_reg <= CM_IDLE;
      cpage_reg <= 3'h0;
      cbyte_reg <= 3'h0;
      timer_reg <= 20'h00000;
      busy_reg <= 1'b0;
      array_we <= 1'b0;
      array_addr <= 13'h0000;
      array_data <= 8'h00;
    end else if (ce) begin
      array_we <= 1'b0;
      case (cm_state_reg)
        CM_IDLE: begin
          if (commit_go) begin
            busy_reg <= 1'b1;
            cpage_reg <= 3'h0; // [RULE5]
            cbyte_reg <= 3'h0;
            cm_state_reg <= CM_BYTE;
          end
        end
        CM_BYTE: begin
          // only loaded positions, and never under low voltage
          if (loaded_reg[cidx] && !lv_s) begin
            array_we <= 1'b1; // [RULE7] [RULE10]
            array_addr <= {page_of(base_page_reg, cpage_reg), cbyte_reg}; // [RULE5] [RULE17]
            array_data <= cache_mem[cidx];
          end
          cbyte_reg <= cbyte_reg + 3'h1;
          if (cbyte_reg == `LAST_BYTE_POS) begin
            timer_reg <= 20'h00000;
            cm_state_reg <= CM_WAIT;
          end
        end
        CM_WAIT: begin
          // full cycle time even for a partial page
          if (timer_reg >= write_cycles - 20'h00001) begin // [RULE6] [RULE15]
            if (cpage_reg == last_page_reg) begin
              busy_reg <= 1'b0;
              cm_state_reg <= CM_IDLE;
            end else begin
              cpage_reg <= cpage_reg + 3'h1; // [RULE5]
              cm_state_reg <= CM_BYTE;
            end
          end else begin
            timer_reg <= timer_reg + 20'h00001;
          end
        end
        default: begin
          cm_state_reg <= CM_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby once the bus is idle and no write is running
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standby <= 1'b1;
    end else if (ce) begin
      standby <= (bus_state_reg == ST_IDLE) && !busy_reg && !commit_go && !start_det; // [RULE8] [RULE9]
    end
  end

endmodule

// File: tb/bus_master_model.sv
module bus_master_model (
  // bus clock and own data drive
  output logic scl,
  output logic sda_drv,
  // resolved data wire
  input wire logic sda_w
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////
  // idle bus: both lines high, clock stands still
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // one bus clock: data set mid-low, sampled just before the fall
  task automatic clock_bit(input logic b, output logic r);
    #20 sda_drv = b;
    #20 scl = 1'b1;
    #38 r = sda_w;
    #2 scl = 1'b0;
  endtask

  // start: data falls while the clock is high
  task automatic start;
    #20 sda_drv = 1'b1;
    #20 scl = 1'b1;
    #20 sda_drv = 1'b0;
    #20 scl = 1'b0;
  endtask

  // stop: data rises while the clock is high, clock then stays high
  task automatic stop;
    #20 sda_drv = 1'b0;
    #20 scl = 1'b1;
    #20 sda_drv = 1'b1;
  endtask

  // one byte, msb first, then a released ninth clock for the ack
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, r);
    ack = !r;
  endtask
endmodule

// File: tb/eeprom_cache_asserts.sv
module eeprom_cache_asserts #(
  parameter [19:0] write_cycles = 20'h7A120
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // data pin drive
  input wire sda_o,
  input wire sda_oe,
  // supply monitor
  input wire low_voltage_i,
  input wire monitor_en,
  // array port and power state
  input wire array_we,
  input wire [12:0] array_addr,
  input wire standby
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////
  // cycles since the last array write, saturating
  logic [19:0] gap_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 20'hFFFFF;
    end else if (array_we) begin
      gap_reg <= 20'h0;
    end else if (gap_reg != 20'hFFFFF) begin
      gap_reg <= gap_reg + 20'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  sda_open_drain_a: assert property (sda_oe |-> sda_o == 1'b0)
    else $error("data line driven high");
  monitor_follow_a: assert property (monitor_en == !standby)
    else $error("monitor power not tied to standby");
  low_supply_a: assert property (low_voltage_i [*8] |-> !array_we)
    else $error("array written under low supply");
  page_walk_a: assert property (array_we && $past(array_we) |-> array_addr == $past(array_addr) + 13'h1)
    else $error("adjacent writes not at adjacent bytes");
  page_gap_a: assert property (array_we && gap_reg > 20'h00007 |-> gap_reg >= write_cycles - 20'h00001)
    else $error("page write cycle cut short");
  write_awake_a: assert property (array_we |-> !standby)
    else $error("array written in standby");
  ack_awake_a: assert property (sda_oe |-> !standby)
    else $error("ack driven in standby");
  busy_no_ack_a: assert property (array_we |-> !sda_oe)
    else $error("ack given while writing");
endmodule

// File: tb/eeprom_write_cache_unaligned_test.sv
`include "eeprom_cache_regs.vh"

module eeprom_write_cache_unaligned_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [19:0] wcyc = 20'h000C8;
  // clock, reset and straps
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic low_v = 1'b0;
  logic [2:0] strap = 3'h0;
  integer seed = 32'h354943ac;
  int err_total = 0;
  int cmp_count = 0;
  // bus wires and design outputs
  wire scl;
  wire sda_drv;
  wire sda_w;
  wire sda_o, sda_oe, monitor_en, array_we, standby;
  wire [12:0] array_addr;
  wire [7:0] array_data;
  // expected array writes and the bench's cache image
  logic [20:0] exp_q[$];
  logic [7:0] img[64];
  logic [63:0] ld;

  ////////////////////////////////////////////////////////////
  // pulled-up data wire, low when either side pulls
  assign sda_w = sda_drv & ~(sda_oe & ~sda_o);
  always #5 clk = ~clk;

  bus_master_model m (.scl(scl), .sda_drv(sda_drv), .sda_w(sda_w));
  eeprom_write_cache #(.write_cycles(wcyc)) dut (.clk(clk), .resetn(resetn), .ce(1'b1), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_bit0(strap[0]),
    .chip_select_bit1(strap[1]), .chip_select_bit2(strap[2]), .low_voltage_i(low_v),
    .monitor_en(monitor_en), .array_we(array_we), .array_addr(array_addr),
    .array_data(array_data), .standby(standby));

  ////////////////////////////////////////////////////////////
  // shared mismatch report
  task automatic cmp_val(input logic [20:0] e, input logic [20:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: exp %0h got %0h", $time, e, g);
    end
  endtask
  // array write compare
  task automatic cmp_wr(input logic [20:0] e, input logic [20:0] g);
    cmp_val(e, g);
  endtask
  // flag or ack compare
  task automatic cmp_bit(input logic e, input logic g);
    cmp_val({20'h0, e}, {20'h0, g});
  endtask

  // verdict and end of run
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one write: control, address, n random bytes, stop; notes the commit
  task automatic wr(input logic [2:0] cs, input logic [12:0] a, input int n, input logic ok);
    logic ack;
    logic [7:0] d;
    logic [5:0] p;
    ld = 64'h0;
    p = {3'h0, a[2:0]};
    m.start();
    m.send({`CTRL_CODE, cs, 1'b0}, ack);
    cmp_bit(ok, ack);
    if (ack) begin
      m.send({3'h0, a[12:8]}, ack);
      m.send(a[7:0], ack);
      for (int i = 0; i < n; i++) begin
        d = $random(seed);
        m.send(d, ack);
        img[p] = d;
        ld[p] = 1'b1;
        p++;
      end
      for (int k = 0; k < 64; k++) begin
        if (ld[k] && !low_v)
          exp_q.push_back({a[12:3] + 10'(k / 8), 3'(k % 8), img[k]});
      end
    end
    m.stop();
  endtask

  // wait for standby under a bound, then check idle state
  task automatic settle;
    int t;
    t = 0;
    repeat (6) @(posedge clk);
    while (standby !== 1'b1 && t < 8 * (wcyc + 20)) begin
      @(posedge clk);
      t++;
    end
    #1;
    cmp_bit(1'b1, standby);
    cmp_bit(1'b0, monitor_en);
    cmp_wr(21'h0, 21'(exp_q.size()));
  endtask

  ////////////////////////////////////////////////////////////
  // write watcher: each array write takes the oldest note
  always @(negedge clk) begin
    if (array_we === 1'b1 && exp_q.size() > 0)
      cmp_wr(exp_q.pop_front(), {array_addr, array_data});
    else if (array_we === 1'b1)
      cmp_wr(21'h000001, 21'(exp_q.size()));
  end

  // watchdog
  initial begin
    #300us;
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    logic ack;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    strap = $random(seed);
    repeat (3) @(posedge clk);
    #1;
    cmp_bit(1'b1, standby);
    wr(strap ^ 3'h4, 13'h0040, 3, 1'b0);
    settle();
    wr(strap, 13'h0012, 2, 1'b1);
    m.start();
    m.send({`CTRL_CODE, strap, 1'b0}, ack);
    cmp_bit(1'b0, ack);
    m.stop();
    settle();
    wr(strap, 13'h1FF2, 66, 1'b1);
    settle();
    low_v = 1'b1;
    wr(strap, 13'h0105, 5, 1'b1);
    settle();
    low_v = 1'b0;
    wr(strap, 13'h0200, 0, 1'b1);
    settle();
    // read direction is refused at the control byte
    m.start();
    m.send({`CTRL_CODE, strap, 1'b1}, ack);
    cmp_bit(1'b0, ack);
    m.stop();
    settle();
    final_report();
  end
endmodule

bind eeprom_write_cache eeprom_cache_asserts #(.write_cycles(write_cycles)) chk (.clk(clk), .resetn(resetn),
  .sda_o(sda_o), .sda_oe(sda_oe), .low_voltage_i(low_voltage_i), .monitor_en(monitor_en),
  .array_we(array_we), .array_addr(array_addr), .standby(standby));
